// >>> logic/acs_clock_route.sv
`include "acs_defines.svh"
`default_nettype none
module acs_clock_route (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ctrl_csn,
  input  wire logic       ctrl_cclk,
  input  wire logic       ctrl_cdti,
  output logic            ctrl_cdto,
  output logic            ctrl_cdto_oe,
  input  wire logic       pll_clk_pin,
  input  wire logic       crystal_in_pin,
  input  wire logic       crystal_enable_pin,
  input  wire logic       clk_out_a_disable_pin,
  input  wire logic       preamble_ok,
  input  wire logic       preamble_bad,
  output logic            master_clk_out_a,
  output logic            master_clk_out_b,
  output logic            pll_power_en,
  output logic            crystal_osc_en,
  output logic            adc_power_en,
  output logic            pll_unlocked,
  output logic [1:0]      converter_source_sel,
  output logic [1:0]      transmitter_source_sel,
  output logic            receiver_bypass_en,
  output logic [1:0]      sample_speed_sel,
  output logic [9:0]      master_clk_ratio
);
  localparam int NPIN = 7;
  localparam logic [11:0] GAP_MAX = 12'(`ACS_PREAMBLE_GAP_CYC);
  localparam logic [NPIN-1:0] IDLE = 7'h40; // chip select idles high

  // pin synchronisers; stage 1 feeds stage 2 only
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  assign pin_raw = {ctrl_csn, clk_out_a_disable_pin, crystal_enable_pin,
                    crystal_in_pin, pll_clk_pin, ctrl_cdti, ctrl_cclk};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_comb begin
        filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : filt_q[gi];
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[gi]   <= IDLE[gi];
          s2_q[gi]   <= IDLE[gi];
          s3_q[gi]   <= IDLE[gi];
          filt_q[gi] <= IDLE[gi];
        end else begin
          s1_q[gi]   <= pin_raw[gi];
          s2_q[gi]   <= s1_q[gi];
          s3_q[gi]   <= s2_q[gi];
          filt_q[gi] <= filt_d[gi];
        end
      end
    end
  endgenerate
  logic cclk_rise, cclk_fall;
  assign cclk_rise = filt_d[0] & ~filt_q[0];
  assign cclk_fall = ~filt_d[0] & filt_q[0];

  // serial control port and registers
  logic [7:0]  clkctl_q, clkctl_d, spdctl_q, spdctl_d, route_q, route_d;
  logic [15:0] shin_q, shin_d;
  logic [7:0]  shout_q, shout_d;
  logic [4:0]  bits_q, bits_d;
  logic        rd_q, rd_d, cdto_q, cdto_d, oe_q, oe_d;
  logic        unlock_q, unlock_d, sel_xtal_q, sel_xtal_d;
  logic [7:0]  rdata;
  logic [6:0]  raddr;

  function automatic logic [7:0] acs_read(input logic [6:0] a,
      input logic [7:0] c, input logic [7:0] s, input logic [7:0] r,
      input logic [7:0] st);
    case (a)
      `ACS_ADDR_CLOCK_CTRL: acs_read = c;
      `ACS_ADDR_SPEED_CTRL: acs_read = s;
      `ACS_ADDR_STATUS:     acs_read = st;
      `ACS_ADDR_ROUTE:      acs_read = r;
      default:              acs_read = 8'h00;
    endcase
  endfunction : acs_read

  assign raddr = {shin_q[5:0], filt_d[1]};
  assign rdata = acs_read(raddr, clkctl_q, spdctl_q, route_q,
                          {6'h00, sel_xtal_q, unlock_q});

  always_comb begin
    clkctl_d = clkctl_q;
    spdctl_d = spdctl_q;
    route_d  = route_q;
    shin_d   = shin_q;
    shout_d  = shout_q;
    bits_d   = bits_q;
    rd_d     = rd_q;
    cdto_d   = cdto_q;
    oe_d     = oe_q;
    if (filt_q[6]) begin
      bits_d = 5'h00;
      oe_d   = 1'b0;
      cdto_d = 1'b0;
    end else if (cclk_rise && bits_q < `ACS_FRAME_BITS) begin
      shin_d = {shin_q[14:0], filt_d[1]};
      bits_d = bits_q + 5'h01;
      if (bits_q == 5'h00) begin
        rd_d = ~filt_d[1];
      end
      if (bits_q == `ACS_HDR_BITS - 5'h01 && rd_q) begin
        shout_d = rdata;
      end
      if (bits_q == `ACS_FRAME_BITS - 5'h01 && !rd_q) begin
        // clock mode writes leave the routing register alone
        case (shin_q[13:7])
          `ACS_ADDR_CLOCK_CTRL: clkctl_d = {shin_q[6:0], filt_d[1]};
          `ACS_ADDR_SPEED_CTRL: spdctl_d = {shin_q[6:0], filt_d[1]};
          `ACS_ADDR_ROUTE:      route_d  = {shin_q[6:0], filt_d[1]};
          default: ;
        endcase
      end
    end else if (cclk_fall && rd_q && bits_q >= `ACS_HDR_BITS
                 && bits_q < `ACS_FRAME_BITS) begin
      cdto_d  = shout_q[7];
      shout_d = {shout_q[6:0], 1'b0};
      oe_d    = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkctl_q <= `ACS_CLOCK_CTRL_RESET;
      spdctl_q <= `ACS_SPEED_CTRL_RESET;
      route_q  <= `ACS_ROUTE_RESET;
      shin_q   <= 16'h0000;
      shout_q  <= 8'h00;
      bits_q   <= 5'h00;
      rd_q     <= 1'b0;
      cdto_q   <= 1'b0;
      oe_q     <= 1'b0;
    end else begin
      clkctl_q <= clkctl_d;
      spdctl_q <= spdctl_d;
      route_q  <= route_d;
      shin_q   <= shin_d;
      shout_q  <= shout_d;
      bits_q   <= bits_d;
      rd_q     <= rd_d;
      cdto_q   <= cdto_d;
      oe_q     <= oe_d;
    end
  end

  // lock supervision
  logic [11:0] gap_q, gap_d;
  logic [1:0]  mode, ocks, icks, xtl, speed;
  assign mode  = clkctl_q[`ACS_FLD_MODE];
  assign ocks  = clkctl_q[`ACS_FLD_OCKS];
  assign icks  = clkctl_q[`ACS_FLD_ICKS];
  assign xtl   = clkctl_q[`ACS_FLD_XTL];
  assign speed = spdctl_q[`ACS_FLD_SPEED];
  always_comb begin
    gap_d    = gap_q;
    unlock_d = unlock_q;
    if (mode == acs_pkg::ACS_MODE_XTAL) begin
      // pll stopped, nothing to lock to
      gap_d    = 12'h000;
      unlock_d = 1'b1;
    end else if (preamble_bad || gap_q >= GAP_MAX) begin
      gap_d    = 12'h000;
      unlock_d = 1'b1;
    end else if (preamble_ok) begin
      gap_d    = 12'h000;
      unlock_d = 1'b0;
    end else begin
      gap_d    = gap_q + 12'h001;
    end
  end

  // glitch-free switch; output taps change only on an internal rise
  acs_pkg::acs_sw_state_t sw_q, sw_d;
  logic want_xtal, cur_lvl, new_lvl, mint_q, mint_d;
  logic [3:0] div_q, div_d;
  logic [1:0] osel_q, osel_d;
  always_comb begin
    unique case (acs_pkg::acs_clk_mode_t'(mode))
      acs_pkg::ACS_MODE_PLL:      want_xtal = 1'b0;
      acs_pkg::ACS_MODE_XTAL:     want_xtal = 1'b1;
      acs_pkg::ACS_MODE_AUTO:     want_xtal = unlock_q;
      acs_pkg::ACS_MODE_XTAL_MON: want_xtal = 1'b1;
    endcase
  end
  assign cur_lvl = sel_xtal_q ? filt_q[3] : filt_q[2];
  assign new_lvl = sel_xtal_q ? filt_q[2] : filt_q[3];
  always_comb begin
    sw_d       = sw_q;
    sel_xtal_d = sel_xtal_q;
    mint_d     = 1'b0;
    unique case (sw_q)
      acs_pkg::ACS_SW_RUN: begin
        mint_d = cur_lvl;
        if (want_xtal != sel_xtal_q && !cur_lvl) begin
          sw_d   = acs_pkg::ACS_SW_DRAIN;
          mint_d = 1'b0;
        end
      end
      acs_pkg::ACS_SW_DRAIN: begin
        if (!new_lvl) begin
          sel_xtal_d = ~sel_xtal_q;
          sw_d       = acs_pkg::ACS_SW_ARM;
        end
      end
      acs_pkg::ACS_SW_ARM: sw_d = cur_lvl ? sw_q : acs_pkg::ACS_SW_RUN;
      default:             sw_d = acs_pkg::ACS_SW_RUN;
    endcase
    div_d = (mint_d & ~mint_q) ? div_q + 4'h1 : div_q;
    osel_d = (mint_d & ~mint_q) ? (sel_xtal_q ? 2'b00 : ocks) : osel_q;
  end

  // output stage, every port from a flip-flop
  logic outa_d, outb_d;
  logic [9:0] ratio_d;
  function automatic logic [9:0] acs_ratio(input logic [1:0] ic,
      input logic [1:0] sp);
    logic [9:0] base;
    base = 10'h000;
    case (ic)
      2'b00: base = (sp == 2'b00) ? 10'h100 : 10'h000;
      2'b01: base = (sp == 2'b00) ? 10'h180 : 10'h000;
      2'b10: base = 10'h200;
      2'b11: base = 10'h300;
    endcase
    case (sp)
      2'b00:   acs_ratio = base;
      2'b01:   acs_ratio = base >> 1;
      2'b10:   acs_ratio = base >> 2;
      default: acs_ratio = 10'h000;
    endcase
  endfunction : acs_ratio
  always_comb begin
    unique case (osel_q)
      2'b00: outa_d = mint_q;
      2'b01: outa_d = div_q[0];
      2'b10: outa_d = div_q[1];
      2'b11: outa_d = div_q[2];
    endcase
    outb_d = div_q[osel_q];
    if (sel_xtal_q) begin
      ratio_d = acs_ratio(icks, speed);
    end else begin
      // recovered clock taken as 512fs
      ratio_d = 10'h200 >> ocks;
    end
    if (filt_q[5]) begin
      outa_d = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= 12'h000;
      unlock_q <= 1'b1;
      sw_q <= acs_pkg::ACS_SW_RUN;
      sel_xtal_q <= 1'b1;
      mint_q <= 1'b0;
      div_q <= 4'h0;
      osel_q <= 2'b00;
      master_clk_out_a <= 1'b0;
      master_clk_out_b <= 1'b0;
      pll_power_en <= 1'b0;
      crystal_osc_en <= 1'b1;
      adc_power_en <= 1'b1;
      pll_unlocked <= 1'b1;
      converter_source_sel <= 2'b00;
      transmitter_source_sel <= 2'b00;
      receiver_bypass_en <= 1'b0;
      sample_speed_sel <= 2'b00;
      master_clk_ratio <= 10'h000;
      ctrl_cdto <= 1'b0;
      ctrl_cdto_oe <= 1'b0;
    end else begin
      gap_q <= gap_d;
      unlock_q <= unlock_d;
      sw_q <= sw_d;
      sel_xtal_q <= sel_xtal_d;
      mint_q <= mint_d;
      div_q <= div_d;
      osel_q <= osel_d;
      master_clk_out_a <= outa_d;
      master_clk_out_b <= outb_d;
      pll_power_en <= (mode != acs_pkg::ACS_MODE_XTAL);
      crystal_osc_en <= !(mode == acs_pkg::ACS_MODE_PLL && xtl == 2'b11
                          && !filt_q[4]);
      adc_power_en <= (speed != 2'b10);
      pll_unlocked <= unlock_q;
      converter_source_sel <= route_q[`ACS_FLD_CONV_SRC];
      transmitter_source_sel <= route_q[`ACS_FLD_TX_SRC];
      receiver_bypass_en <= (route_q[`ACS_FLD_TX_SRC]
                             == acs_pkg::ACS_SRC_DIR);
      sample_speed_sel <= speed;
      master_clk_ratio <= ratio_d;
      ctrl_cdto <= cdto_q;
      ctrl_cdto_oe <= oe_q;
    end
  end
endmodule : acs_clock_route
`default_nettype wire

// >>> logic/acs_defines.svh
// Functional notes
// - route converter and serial out from three sources
// - transmitter source selectable, plus receiver bypass path
// - two-bit clock mode picks pll or crystal
// - mode 2 falls back to crystal on unlock
// - mode 3 crystal clock, pll kept running
// - mode 0 stops oscillator if field 11, pin low
// - clock mode field resets to 01
// - clock mode changes never touch audio routing
// - pll mode output ratio sets both master outputs
// - crystal mode: out a equals reference, b half
// - disable pin high holds output a low
// - output clock ratio field resets to 01
// - input ratio field sets crystal mode master ratio
// - speed field normal, double, quad; resets normal
// - converter powered down during quad speed
// - bad preamble or spacing declares pll unlocked
// - reference crystal field selects crystal frequency; code decodes only 11, for the oscillator stop
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_ADDR_CLOCK_CTRL   7'h00
`define ACS_ADDR_SPEED_CTRL   7'h01
`define ACS_ADDR_STATUS       7'h02
`define ACS_ADDR_ROUTE        7'h08
`define ACS_CLOCK_CTRL_RESET  8'h05
`define ACS_SPEED_CTRL_RESET  8'h00
`define ACS_ROUTE_RESET       8'h00
`define ACS_FLD_MODE          1:0
`define ACS_FLD_OCKS          3:2
`define ACS_FLD_ICKS          5:4
`define ACS_FLD_XTL           7:6
`define ACS_FLD_SPEED         1:0
`define ACS_FLD_CONV_SRC      1:0
`define ACS_FLD_TX_SRC        3:2
`define ACS_PREAMBLE_GAP_NS   10000
`define ACS_CLK_PERIOD_NS     5
`define ACS_PREAMBLE_GAP_CYC  (`ACS_PREAMBLE_GAP_NS / `ACS_CLK_PERIOD_NS)
`define ACS_FRAME_BITS        5'h10
`define ACS_HDR_BITS          5'h08
`endif

// >>> logic/acs_pkg.sv
`default_nettype none
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_SW_RUN   = 2'b00,
    ACS_SW_DRAIN = 2'b01,
    ACS_SW_ARM   = 2'b10
  } acs_sw_state_t;
  typedef enum logic [1:0] {
    ACS_MODE_PLL      = 2'b00,
    ACS_MODE_XTAL     = 2'b01,
    ACS_MODE_AUTO     = 2'b10,
    ACS_MODE_XTAL_MON = 2'b11
  } acs_clk_mode_t;
  typedef enum logic [1:0] {
    ACS_SRC_ADC  = 2'b00,
    ACS_SRC_SERIAL_AUDIO_IN = 2'b01,
    ACS_SRC_DIR  = 2'b10
  } acs_src_t;
endpackage : acs_pkg
`default_nettype wire

// >>> tb/acs_clock_route_checker.sv
`default_nettype none
module acs_clock_route_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clk_out_a_disable_pin,
  input wire logic       preamble_bad,
  input wire logic       master_clk_out_a,
  input wire logic       pll_power_en,
  input wire logic       crystal_osc_en,
  input wire logic       adc_power_en,
  input wire logic       pll_unlocked,
  input wire logic [1:0] transmitter_source_sel,
  input wire logic       receiver_bypass_en,
  input wire logic [1:0] sample_speed_sel,
  input wire logic [9:0] master_clk_ratio
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  bypass_flag_a: assert property (
    receiver_bypass_en == (transmitter_source_sel == 2'h2))
    else $error("bypass flag wrong");
  out_a_held_a: assert property (
    clk_out_a_disable_pin [*6] |-> !master_clk_out_a)
    else $error("out a not held low");
  adc_speed_a: assert property (
    $stable(sample_speed_sel) [*2] |->
      adc_power_en == (sample_speed_sel != 2'h2))
    else $error("converter power wrong");
  pll_off_a: assert property (
    (!pll_power_en) [*3] |-> crystal_osc_en && pll_unlocked)
    else $error("pll off without crystal");
  osc_stop_a: assert property (
    !crystal_osc_en |-> pll_power_en)
    else $error("oscillator stopped outside pll mode");
  ratio_legal_a: assert property (
    master_clk_ratio inside {10'h000, 10'h040, 10'h080, 10'h0C0,
                             10'h100, 10'h180, 10'h200, 10'h300})
    else $error("illegal clock ratio");
  // pin must be quiet first: resuming after disable is not a switch
  runt_high_a: assert property (
    (!clk_out_a_disable_pin) [*8] ##0 $rose(master_clk_out_a) |=>
      master_clk_out_a || clk_out_a_disable_pin)
    else $error("runt high pulse on out a");
  runt_low_a: assert property (
    (!clk_out_a_disable_pin) [*8] ##0 $fell(master_clk_out_a) |=>
      !master_clk_out_a)
    else $error("runt low pulse on out a");
  unlock_flag_a: assert property (
    preamble_bad |-> ##[1:4] pll_unlocked)
    else $error("bad preamble did not unlock");
  cover property (clk_out_a_disable_pin [*6]);
  cover property ($rose(receiver_bypass_en));
  cover property ($fell(crystal_osc_en));
endmodule : acs_clock_route_checker
bind acs_clock_route acs_clock_route_checker u_acs_clock_route_checker (
  .clk, .rst, .clk_out_a_disable_pin, .preamble_bad, .master_clk_out_a,
  .pll_power_en, .crystal_osc_en, .adc_power_en, .pll_unlocked,
  .transmitter_source_sel, .receiver_bypass_en, .sample_speed_sel,
  .master_clk_ratio
);
`default_nettype wire

// >>> tb/acs_host_model.sv
`default_nettype none
module acs_host_model (
  input  wire logic clk,
  output logic      csn,
  output logic      cclk,
  output logic      cdti,
  input  wire logic cdto,
  input  wire logic cdto_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    csn = 1'b1;
    cclk = 1'b0;
    cdti = 1'b0;
  end
  // 8 clk phases: twice the minimum, covers the pin filter delay
  task xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
            output logic [7:0] q);
    logic [15:0] f;
    int          k;
    f = {w, a, d};
    q = 8'h00;
    @(posedge clk);
    csn <= 1'b0;
    for (k = 15; k >= 0; k--) begin
      repeat (8) @(posedge clk);
      cdti <= f[k];
      repeat (8) @(posedge clk);
      cclk <= 1'b1;
      if (k < 8 && cdto_oe)
        q[k] = cdto;
      repeat (8) @(posedge clk);
      cclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    csn <= 1'b1;
    repeat (40) @(posedge clk);
  endtask : xfer
endmodule : acs_host_model
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [6:0]  a;
    logic [7:0]  d;
    logic [10:0] e;
  } acs_row_t;
  logic clk, rst, csn, cclk, cdti, cdto, cdto_oe, pll, xtal, xen, dis;
  logic pre_ok, pre_bad, pre_en, oa, ob, pll_en, osc_en, adc_en, unl, byp;
  logic [1:0] conv, tx, spd;
  logic [9:0] ratio;
  logic [8:0] pc;
  logic [2:0] xc;
  logic [7:0] q;
  int bad_count, comparisons, i;
  // ocks 0 only at normal speed, where that ratio is allowed
  acs_row_t rows [14] = '{
    '{7'h00, 8'h04, 11'h500}, '{7'h00, 8'h08, 11'h480},
    '{7'h00, 8'h0C, 11'h440}, '{7'h00, 8'h00, 11'h600},
    '{7'h00, 8'h01, 11'h100}, '{7'h00, 8'h11, 11'h180},
    '{7'h00, 8'h21, 11'h200}, '{7'h00, 8'h31, 11'h300},
    '{7'h01, 8'h02, 11'h002}, '{7'h01, 8'h01, 11'h005},
    '{7'h01, 8'h00, 11'h004}, '{7'h08, 8'h04, 11'h004},
    '{7'h08, 8'h02, 11'h002}, '{7'h08, 8'h09, 11'h019}
  };
  acs_host_model u_acs_host_model (.clk(clk), .csn(csn), .cclk(cclk),
    .cdti(cdti), .cdto(cdto), .cdto_oe(cdto_oe));
  acs_clock_route u_acs_clock_route (
    .clk(clk), .rst(rst), .ctrl_csn(csn), .ctrl_cclk(cclk),
    .ctrl_cdti(cdti), .ctrl_cdto(cdto), .ctrl_cdto_oe(cdto_oe),
    .pll_clk_pin(pll), .crystal_in_pin(xtal), .crystal_enable_pin(xen),
    .clk_out_a_disable_pin(dis), .preamble_ok(pre_ok),
    .preamble_bad(pre_bad), .master_clk_out_a(oa), .master_clk_out_b(ob),
    .pll_power_en(pll_en), .crystal_osc_en(osc_en), .adc_power_en(adc_en),
    .pll_unlocked(unl), .converter_source_sel(conv),
    .transmitter_source_sel(tx), .receiver_bypass_en(byp),
    .sample_speed_sel(spd), .master_clk_ratio(ratio));
  always #2.5 clk = ~clk;
  // sources differ in rate so a wrong pick shows in the period
  always @(posedge clk) begin
    pc <= pc + 9'h001;
    xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
    pll <= pc[1];
    xtal <= osc_en && (xc < 3'h3);
    pre_ok <= pre_en && (pc == 9'h000);
  end
  task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [10:0] obs(input logic [6:0] a);
    if (a == 7'h08)
      return {6'h00, byp, tx, conv};
    if (a == 7'h01)
      return {8'h00, adc_en, spd};
    return {pll_en, ratio};
  endfunction : obs
  task wr(input logic [6:0] a, input logic [7:0] d);
    u_acs_host_model.xfer(1'b1, a, d, q);
  endtask : wr
  task per(input string nm, input logic b, input int e);
    logic p;
    logic c;
    int   r;
    int   n;
    p = 1'b1;
    r = 0;
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      c = b ? ob : oa;
      if (c && !p)
        r++;
      if (r == 1)
        n++;
      p = c;
    end
    chk(nm, 11'(e), 11'(n));
  endtask : per
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    {clk, rst, xen, dis, pre_bad, pre_en, pll, xtal, pre_ok} = 9'h088;
    pc = 9'h000;
    xc = 3'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("reset clock", 11'h100, obs(7'h00));
    chk("reset speed", 11'h004, obs(7'h01));
    chk("reset route", 11'h000, obs(7'h08));
    u_acs_host_model.xfer(1'b0, 7'h00, 8'h00, q);
    chk("clock read", 11'h005, {3'h0, q});
    $display("reset test done");
    for (i = 0; i < 14; i++) begin
      wr(rows[i].a, rows[i].d);
      #1;
      chk("row", rows[i].e, obs(rows[i].a));
    end
    $display("table test done");
    wr(7'h00, 8'h02);
    #1;
    chk("route kept", 11'h019, obs(7'h08));
    for (i = 0; i < 700 && unl !== 1'b0; i++)
      @(posedge clk);
    #1;
    chk("locked", 11'h000, {10'h000, unl});
    if (unl !== 1'b0)
      print_verdict();
    repeat (20) @(posedge clk);
    per("pll out a", 1'b0, 4);
    per("pll out b", 1'b1, 8);
    @(posedge clk);
    pre_en <= 1'b0;
    pre_bad <= 1'b1;
    @(posedge clk);
    pre_bad <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk("unlocked", 11'h001, {10'h000, unl});
    per("fallback out a", 1'b0, 6);
    per("fallback out b", 1'b1, 12);
    $display("fallback test done");
    @(posedge clk);
    dis <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("out a low", 11'h000, {10'h000, oa});
    per("disabled out a", 1'b0, 0);
    @(posedge clk);
    dis <= 1'b0;
    repeat (20) @(posedge clk);
    per("enabled out a", 1'b0, 6);
    $display("disable test done");
    wr(7'h00, 8'h03);
    repeat (20) @(posedge clk);
    #1;
    chk("mode 3 pll on", 11'h001, {10'h000, pll_en});
    per("mode 3 out a", 1'b0, 6);
    wr(7'h00, 8'hC0);
    #1;
    chk("osc stopped", 11'h000, {10'h000, osc_en});
    @(posedge clk);
    xen <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("osc running", 11'h001, {10'h000, osc_en});
    $display("mode test done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
